// >>> jbs_pkg.sv
// shared constants and types for the boundary-scan instruction block
// assumes the test clock and the system clock are unrelated in phase
`default_nettype none

package jbs_pkg;

   // ======================================================
   // instruction register
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_IDCODE = 4'h1;
   localparam logic [3:0] OP_SAMPLE_PRELOAD = 4'h2;
   localparam logic [3:0] OP_FORCE_RESET = 4'hc;
   localparam logic [3:0] OP_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
   localparam logic [3:0] IR_RESET_VALUE = OP_IDCODE;

   // ======================================================
   // identification register layout
   localparam int ID_WIDTH = 32;
   localparam int ID_VERSION_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MAKER_LSB = 1;
   localparam logic ID_MARKER = 1'h1;

   // ======================================================
   // mcu control/status register
   localparam int MCS_DISABLE_POS = 7;
   localparam int MCS_FLAG_POS = 4;
   localparam logic MCS_DISABLE_RESET = 1'h0;
   localparam logic MCS_FLAG_RESET = 1'h0;
   localparam logic [2:0] TIMED_WRITE_CYCLES = 3'h4;

   // ======================================================
   // types
   typedef struct packed {
      logic strobe;
      logic [7:0] data;
   } jbs_reg_wr_t;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jbs_tap_state_t;

endpackage

`default_nettype wire

// >>> jbs_chain.sv
// boundary-scan chain: capture/shift stages with update latches behind
// assumes control strobes come from the tap controller on the same clock
`timescale 1ns/1ps
`default_nettype none

module jbs_chain #(
   parameter int LEN = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic tdi,
   input wire logic [LEN-1:0] cap_in,
   output logic so,
   output logic [LEN-1:0] latch
);

   logic [LEN-1:0] stage;

   // ======================================================
   // per-cell stages, lsb nearest the serial output
   genvar i;
   generate
      for (i = 0; i < LEN; i++) begin : g_cell
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage[i] <= 1'h0;
            end else if (capture) begin
               stage[i] <= cap_in[i];
            end else if (shift) begin
               stage[i] <= (i == LEN - 1) ? tdi : stage[(i + 1) % LEN];
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               latch[i] <= 1'h0;
            end else if (update) begin
               latch[i] <= stage[i];
            end
         end
      end
   endgenerate

   assign so = stage[0];

endmodule

`default_nettype wire

// >>> jbs_tap.sv
// Contract
// RQ1: instruction register is four bits, sixteen possible opcodes.
// RQ2: no high-impedance instruction; force-reset tri-states pins instead.
// RQ3: all shift paths move least significant bit first.
// RQ4: opcode 0 puts the boundary chain between tdi and tdo.
// RQ5: chain covers pull-up disable, output control, output and input data.
// RQ6: analog/digital boundary of off-chip analog circuits is in the chain.
// RQ7: under opcode 0 output latches drive pins immediately.
// RQ8: opcode 0 captures pins, shifts chain, update applies to pins.
// RQ9: opcode 1 selects 32-bit id with version, part and maker fields.
// RQ10: after power-up the instruction register holds the id opcode.
// RQ11: id opcode capture loads id value, shift moves it out.
// RQ12: opcode 2 captures pins and shifts chain without disturbing system.
// RQ13: opcode 2 update loads latches but keeps them off the pins.
// RQ14: opcode c selects one-bit reset register, tap itself not reset.
// RQ15: device reset follows reset register bit directly, unlatched.
// RQ16: under opcode c only shift is active on the reset register.
// RQ17: opcode f selects bypass; capture loads zero, shift passes data.
// RQ18: disable bit 7 zero enables port if fuse programmed; one disables.
// RQ19: disable bit changes only on two equal writes within four cycles.
// RQ20: scan-reset flag sets on scan reset, clears at power-on or written zero.
// RQ21: unassigned opcodes select the bypass register.
//
// top of the boundary-scan instruction logic: tap controller on tck, status
// register on ref_clk; assumes pin cells around it map chain bits to pads
`timescale 1ns/1ps
`default_nettype none

module jbs_tap #(
   parameter int CHAIN_LEN = 16,
   parameter logic [3:0] ID_VERSION = 4'h1,     // arbitrary value
   parameter logic [15:0] ID_PART = 16'h1234,   // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h0aa    // arbitrary value
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic test_port_enable_fuse,
   input wire logic [CHAIN_LEN-1:0] pin_sample,
   output logic [CHAIN_LEN-1:0] chain_latch,
   output logic chain_drive,
   output logic scan_force_reset,
   input wire jbs_pkg::jbs_reg_wr_t reg_wr,
   output logic [7:0] mcu_control_status,
   output logic test_port_enabled
);

   // ======================================================
   // declarations
   jbs_pkg::jbs_tap_state_t state;
   jbs_pkg::jbs_tap_state_t next_state;
   logic [jbs_pkg::IR_WIDTH-1:0] ir;
   logic [jbs_pkg::IR_WIDTH-1:0] ir_shift;
   logic [jbs_pkg::ID_WIDTH-1:0] id_shift;
   logic bypass_bit;
   logic [CHAIN_LEN-1:0] pin_meta;
   logic [CHAIN_LEN-1:0] pin_sync;
   logic en_meta;
   logic en_sync;
   logic fuse_meta;
   logic fuse_sync;
   logic rst_meta;
   logic rst_sync;
   logic test_port_disable_bit;
   logic scan_reset_flag;
   logic arm_val;
   logic [2:0] arm_cnt;
   logic sel_chain;
   logic sel_id;
   logic sel_reset;
   logic chain_so;
   logic chain_cap;
   logic chain_sh;
   logic chain_upd;
   logic next_tdo;
   logic [jbs_pkg::ID_WIDTH-1:0] id_value;

   // id layout: version, part, maker, then the fixed marker bit in the lsb
   assign id_value = {ID_VERSION, ID_PART, ID_MAKER, jbs_pkg::ID_MARKER}; // see RQ9

   // ======================================================
   // crossings into the tck domain
   // port enable from the ref_clk side; the tap reads only the second stage
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         en_meta <= 1'h0;
         en_sync <= 1'h0;
      end else begin
         en_meta <= test_port_enabled;
         en_sync <= en_meta;
      end
   end

   // pin levels are synced bit by bit: a capture that meets a pin edge may
   // mix old and new levels, which a level-sampling test tolerates
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_sample;
         pin_sync <= pin_meta;
      end
   end

   // ======================================================
   // tap state machine; a disabled port is parked in test-logic-reset
   // tms needs no synchroniser: the controller moves it away from the rising tck edge
   always_comb begin
      next_state = state;
      unique case (state)
         jbs_pkg::TAP_RESET: next_state = tms ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_IDLE;
         jbs_pkg::TAP_IDLE: next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
         jbs_pkg::TAP_SEL_DR: next_state = tms ? jbs_pkg::TAP_SEL_IR : jbs_pkg::TAP_CAP_DR;
         jbs_pkg::TAP_CAP_DR: next_state = tms ? jbs_pkg::TAP_EXIT1_DR : jbs_pkg::TAP_SHIFT_DR;
         jbs_pkg::TAP_SHIFT_DR: next_state = tms ? jbs_pkg::TAP_EXIT1_DR : jbs_pkg::TAP_SHIFT_DR;
         jbs_pkg::TAP_EXIT1_DR: next_state = tms ? jbs_pkg::TAP_UPD_DR : jbs_pkg::TAP_PAUSE_DR;
         jbs_pkg::TAP_PAUSE_DR: next_state = tms ? jbs_pkg::TAP_EXIT2_DR : jbs_pkg::TAP_PAUSE_DR;
         jbs_pkg::TAP_EXIT2_DR: next_state = tms ? jbs_pkg::TAP_UPD_DR : jbs_pkg::TAP_SHIFT_DR;
         jbs_pkg::TAP_UPD_DR: next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
         jbs_pkg::TAP_SEL_IR: next_state = tms ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_CAP_IR;
         jbs_pkg::TAP_CAP_IR: next_state = tms ? jbs_pkg::TAP_EXIT1_IR : jbs_pkg::TAP_SHIFT_IR;
         jbs_pkg::TAP_SHIFT_IR: next_state = tms ? jbs_pkg::TAP_EXIT1_IR : jbs_pkg::TAP_SHIFT_IR;
         jbs_pkg::TAP_EXIT1_IR: next_state = tms ? jbs_pkg::TAP_UPD_IR : jbs_pkg::TAP_PAUSE_IR;
         jbs_pkg::TAP_PAUSE_IR: next_state = tms ? jbs_pkg::TAP_EXIT2_IR : jbs_pkg::TAP_PAUSE_IR;
         jbs_pkg::TAP_EXIT2_IR: next_state = tms ? jbs_pkg::TAP_UPD_IR : jbs_pkg::TAP_SHIFT_IR;
         jbs_pkg::TAP_UPD_IR: next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
      endcase
   end

   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         state <= jbs_pkg::TAP_RESET;
      end else if (!en_sync) begin
         state <= jbs_pkg::TAP_RESET; // see RQ18
      end else begin
         state <= next_state;
      end
   end

   // ======================================================
   // instruction register
   // capture loads a fixed pattern so a broken path shows up in the first bits out
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         ir_shift <= jbs_pkg::IR_CAPTURE_VALUE;
      end else if (state == jbs_pkg::TAP_CAP_IR) begin
         ir_shift <= jbs_pkg::IR_CAPTURE_VALUE;
      end else if (state == jbs_pkg::TAP_SHIFT_IR) begin
         ir_shift <= {tdi, ir_shift[jbs_pkg::IR_WIDTH-1:1]}; // see RQ1 see RQ3
      end
   end

   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         ir <= jbs_pkg::IR_RESET_VALUE; // see RQ10
      end else if (state == jbs_pkg::TAP_RESET) begin
         ir <= jbs_pkg::IR_RESET_VALUE; // see RQ10
      end else if (state == jbs_pkg::TAP_UPD_IR) begin
         ir <= ir_shift;
      end
   end

   // ======================================================
   // pin drive select
   // chain_drive follows the ir load itself, not any later dr update
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         chain_drive <= 1'h0;
      end else if (state == jbs_pkg::TAP_RESET) begin
         chain_drive <= 1'h0;
      end else if (state == jbs_pkg::TAP_UPD_IR) begin
         chain_drive <= (ir_shift == jbs_pkg::OP_EXTEST); // see RQ7 see RQ13
      end
   end

   // ======================================================
   // decode; anything not assigned falls through to bypass
   assign sel_chain = (ir == jbs_pkg::OP_EXTEST) || (ir == jbs_pkg::OP_SAMPLE_PRELOAD); // see RQ4 see RQ12
   assign sel_id = (ir == jbs_pkg::OP_IDCODE);
   assign sel_reset = (ir == jbs_pkg::OP_FORCE_RESET); // see RQ14
   // no high-impedance opcode: force-reset leaves pads in their reset tri-state
   // see RQ2 see RQ21

   assign chain_cap = sel_chain && (state == jbs_pkg::TAP_CAP_DR);
   assign chain_sh = sel_chain && (state == jbs_pkg::TAP_SHIFT_DR);
   assign chain_upd = sel_chain && (state == jbs_pkg::TAP_UPD_DR);

   // pin_sample carries pull-up disable, output control, output and input data
   // per port pin, plus the analog/digital boundary cells
   // see RQ5 see RQ6 see RQ8 see RQ12
   jbs_chain #(
      .LEN(CHAIN_LEN)
   ) u_chain (
      .clk(tck),
      .rst_n(nrst),
      .capture(chain_cap),
      .shift(chain_sh),
      .update(chain_upd),
      .tdi(tdi),
      .cap_in(pin_sync),
      .so(chain_so),
      .latch(chain_latch)
   );

   // ======================================================
   // identification and bypass registers
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         id_shift <= '0;
      end else if (sel_id && state == jbs_pkg::TAP_CAP_DR) begin
         id_shift <= id_value; // see RQ11
      end else if (sel_id && state == jbs_pkg::TAP_SHIFT_DR) begin
         id_shift <= {tdi, id_shift[jbs_pkg::ID_WIDTH-1:1]}; // see RQ3 see RQ11
      end
   end

   // bypass captures on every capture-dr; only the tdo mux decides who is seen
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         bypass_bit <= 1'h0;
      end else if (state == jbs_pkg::TAP_CAP_DR) begin
         bypass_bit <= 1'h0; // see RQ17
      end else if (state == jbs_pkg::TAP_SHIFT_DR) begin
         bypass_bit <= tdi; // see RQ17
      end
   end

   // ======================================================
   // reset register
   // the register bit is the reset itself: no update stage, tap untouched
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         scan_force_reset <= 1'h0;
      end else if (sel_reset && state == jbs_pkg::TAP_SHIFT_DR) begin
         scan_force_reset <= tdi; // see RQ15 see RQ16
      end
   end

   // ======================================================
   // serial output, changed on the falling edge for the controller
   always_comb begin
      next_tdo = bypass_bit; // see RQ21
      if (state == jbs_pkg::TAP_SHIFT_IR) begin
         next_tdo = ir_shift[0];
      end else if (sel_chain) begin
         next_tdo = chain_so;
      end else if (sel_id) begin
         next_tdo = id_shift[0];
      end else if (sel_reset) begin
         next_tdo = scan_force_reset;
      end
   end

   always_ff @(negedge tck or negedge nrst) begin
      if (!nrst) begin
         tdo <= 1'h0;
         tdo_oe <= 1'h0;
      end else begin
         tdo <= next_tdo; // see RQ3
         // the pad floats outside the shift states so a shared scan line stays free
         tdo_oe <= (state == jbs_pkg::TAP_SHIFT_IR) || (state == jbs_pkg::TAP_SHIFT_DR);
      end
   end

   // ======================================================
   // system-clock side: crossings
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fuse_meta <= 1'h0;
         fuse_sync <= 1'h0;
      end else begin
         fuse_meta <= test_port_enable_fuse;
         fuse_sync <= fuse_meta;
      end
   end

   // the scan reset is a level held for many tck periods, so two flops suffice
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'h0;
         rst_sync <= 1'h0;
      end else begin
         rst_meta <= scan_force_reset;
         rst_sync <= rst_meta;
      end
   end

   // ======================================================
   // timed double write of the disable bit; a differing value re-arms
   // the count still holds 1 on the fourth cycle after a write, so that write completes
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         arm_cnt <= 3'h0;
         arm_val <= 1'h0;
         test_port_disable_bit <= jbs_pkg::MCS_DISABLE_RESET;
      end else if (reg_wr.strobe) begin
         if (arm_cnt != 3'h0 && reg_wr.data[jbs_pkg::MCS_DISABLE_POS] == arm_val) begin
            test_port_disable_bit <= arm_val; // see RQ19
            arm_cnt <= 3'h0;
         end else begin
            arm_cnt <= jbs_pkg::TIMED_WRITE_CYCLES;
            arm_val <= reg_wr.data[jbs_pkg::MCS_DISABLE_POS];
         end
      end else if (arm_cnt != 3'h0) begin
         arm_cnt <= arm_cnt - 3'h1;
      end
   end

   // ======================================================
   // scan-reset flag
   // set wins over a software clear landing in the same cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scan_reset_flag <= jbs_pkg::MCS_FLAG_RESET;
      end else if (rst_sync) begin
         scan_reset_flag <= 1'h1; // see RQ20
      end else if (reg_wr.strobe && !reg_wr.data[jbs_pkg::MCS_FLAG_POS]) begin
         scan_reset_flag <= 1'h0; // see RQ20
      end
   end

   // ======================================================
   // read-back
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mcu_control_status <= 8'h00;
      end else begin
         mcu_control_status <= 8'h00;
         mcu_control_status[jbs_pkg::MCS_DISABLE_POS] <= test_port_disable_bit;
         mcu_control_status[jbs_pkg::MCS_FLAG_POS] <= scan_reset_flag;
      end
   end

   // ======================================================
   // port enable
   // a disabled port reaches the tap two tck edges after this flop
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         test_port_enabled <= 1'h0;
      end else begin
         test_port_enabled <= fuse_sync && !test_port_disable_bit; // see RQ18
      end
   end

endmodule

`default_nettype wire

// >>> jbs_jtag_host.sv
// behavioural test controller for the tap: drives tck, tms and tdi, reads tdo
// assumes tdo is launched on the falling tck edge
`timescale 1ns/1ps
`default_nettype none

module jbs_jtag_host (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // =====
   // frames
   // tck stands low between frames; tdi flips on idle ticks so no stale bit looks valid
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #15;
      q = tdo;
      tck = 1'b1;
      #15;
      tck = 1'b0;
   endtask

   task automatic reset();
      logic q;
      repeat (8) tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
   endtask

   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b0, ~tdi, q);
      tick(1'b1, ~tdi, q);
      if (ir) tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
      tick(1'b0, ~tdi, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
   endtask
endmodule
`default_nettype wire

// >>> jbs_tap_checker.sv
// port-level assertions for the boundary-scan block
// assumes readback lags a taken write by two ref_clk edges
`timescale 1ns/1ps
`default_nettype none

module jbs_tap_checker #(
   parameter int CHAIN_LEN = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tdi,
   input wire logic tdo_oe,
   input wire logic test_port_enable_fuse,
   input wire logic [CHAIN_LEN-1:0] chain_latch,
   input wire logic scan_force_reset,
   input wire jbs_pkg::jbs_reg_wr_t reg_wr,
   input wire logic [7:0] mcu_control_status,
   input wire logic test_port_enabled
);
   // =====
   // assertions
   a_write_gives_value: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(mcu_control_status[7]) |-> $past(reg_wr.strobe, 2) && $past(reg_wr.data[7], 2) == mcu_control_status[7])
      else $error("disable bit moved without write");
   a_pair_needed: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(mcu_control_status[7]) |-> $past(reg_wr.strobe, 3) || $past(reg_wr.strobe, 4) ||
      $past(reg_wr.strobe, 5) || $past(reg_wr.strobe, 6)) else $error("disable bit moved on one write");
   a_pair_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
      reg_wr.strobe ##1 (reg_wr.strobe && reg_wr.data[7] == $past(reg_wr.data[7])) |->
      ##2 mcu_control_status[7] == $past(reg_wr.data[7], 2)) else $error("paired write lost");
   a_fuse_off: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!test_port_enable_fuse) [*4] |-> !test_port_enabled) else $error("port on without fuse");
   a_port_on: assert property (@(posedge ref_clk) disable iff (!nrst)
      (test_port_enable_fuse && !mcu_control_status[7]) [*5] |-> test_port_enabled) else $error("port off");
   a_disable_off: assert property (@(posedge ref_clk) disable iff (!nrst)
      mcu_control_status[7] [*2] |-> !test_port_enabled) else $error("port on while disabled");
   a_reset_shift: assert property (@(posedge tck) disable iff (!nrst)
      $changed(scan_force_reset) |-> scan_force_reset == $past(tdi) && $past(tdo_oe))
      else $error("reset bit moved outside shift");
   a_latch_update: assert property (@(posedge tck) disable iff (!nrst)
      $changed(chain_latch) |-> !$past(tdo_oe)) else $error("latch moved during shift");
   a_flag_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(mcu_control_status[4]) |-> $past(scan_force_reset, 2)) else $error("flag set without scan reset");
   a_flag_held: assert property (@(posedge ref_clk) disable iff (!nrst)
      scan_force_reset [*8] |-> mcu_control_status[4]) else $error("flag not set");
   a_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(mcu_control_status[4]) |-> $past(reg_wr.strobe, 2) && !$past(reg_wr.data[4], 2))
      else $error("flag cleared without write");
endmodule

bind jbs_tap jbs_tap_checker #(.CHAIN_LEN(CHAIN_LEN)) u_chk (.ref_clk(ref_clk), .nrst(nrst), .tck(tck),
   .tdi(tdi), .tdo_oe(tdo_oe), .test_port_enable_fuse(test_port_enable_fuse), .chain_latch(chain_latch),
   .scan_force_reset(scan_force_reset), .reg_wr(reg_wr), .mcu_control_status(mcu_control_status),
   .test_port_enabled(test_port_enabled));
`default_nettype wire

// >>> jbs_tap_tb.sv
// self-checking bench for the boundary-scan block
// assumes the test controller model in jbs_jtag_host
`timescale 1ns/1ps
`default_nettype none

module jbs_tap_tb;
   localparam int CL = 16;
   localparam logic [3:0] VER = 4'h3; // arbitrary value
   localparam logic [15:0] PART = 16'h6b2d; // arbitrary value
   localparam logic [10:0] MAKER = 11'h155; // arbitrary value
   localparam logic [31:0] ID = {VER, PART, MAKER, jbs_pkg::ID_MARKER};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic fuse = 1'b1;
   logic [CL-1:0] pins = '0;
   jbs_pkg::jbs_reg_wr_t reg_wr = '0;
   logic tck, tms, tdi, tdo, tdo_oe, chain_drive, srst, en;
   logic [CL-1:0] chain_latch;
   logic [7:0] mcs;
   logic [31:0] din, d;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;

   always #2 ref_clk = ~ref_clk;

   jbs_tap #(.CHAIN_LEN(CL), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) DUT (.ref_clk(ref_clk),
      .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse),
      .pin_sample(pins), .chain_latch(chain_latch), .chain_drive(chain_drive), .scan_force_reset(srst),
      .reg_wr(reg_wr), .mcu_control_status(mcs), .test_port_enabled(en));
   jbs_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   // =====
   // helpers
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // gap 0 is a lone write; otherwise a second equal write follows gap cycles later
   task automatic wr(input logic [7:0] v, input int gap);
      for (int i = 0; i <= gap; i++) begin
         @(posedge ref_clk);
         #1;
         reg_wr.strobe = (i == 0 || i == gap);
         reg_wr.data = v;
      end
      @(posedge ref_clk);
      #1;
      reg_wr.strobe = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   function automatic logic [31:0] exp_dr(input logic [3:0] op, input logic [31:0] x);
      case (op)
         jbs_pkg::OP_EXTEST, jbs_pkg::OP_SAMPLE_PRELOAD: return 32'(pins);
         jbs_pkg::OP_IDCODE: return ID;
         jbs_pkg::OP_FORCE_RESET: return 32'h0;
         default: return {24'h0, x[6:0], 1'b0};
      endcase
   endfunction

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         test_done();
      end
   end

   // =====
   // scenarios
   initial begin
      din = $urandom(6);
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      cmp(32'(mcs), 32'h0);
      cmp(32'(en), 32'h1);
      u_host.reset();
      u_host.scan(1'b0, 32, din, d);
      cmp(d, ID);
      cmp(32'(tdo_oe), 32'h0);
      // reset register is loaded with one here, so the device stays held until a zero is shifted into it after the loop
      for (int op = 0; op < 16; op++) begin
         u_host.scan(1'b1, 4, 32'(op), d);
         cmp(d, 32'(jbs_pkg::IR_CAPTURE_VALUE));
         cmp(32'(chain_drive), 32'(op == 0));
         @(posedge ref_clk);
         #1;
         pins = CL'($urandom);
         din = $urandom | 32'h1;
         u_host.scan(1'b0, (op == 0 || op == 2) ? CL : op == 1 ? 32 : op == 12 ? 1 : 8, din, d);
         cmp(d, exp_dr(4'(op), din));
         if (op == 0 || op == 2) cmp(32'(chain_latch), 32'(din[CL-1:0]));
         if (op == 12) cmp(32'(srst), 32'h1);
      end
      repeat (10) @(posedge ref_clk);
      #1;
      cmp(32'(mcs), 32'h10);
      u_host.scan(1'b1, 4, 32'hc, d);
      u_host.scan(1'b0, 1, 32'h0, d);
      cmp(d, 32'h1);
      cmp(32'(srst), 32'h0);
      wr({4'h0, 4'($urandom)}, 0);
      cmp(32'(mcs), 32'h0);
      din = $urandom;
      wr(8'h80 | din[7:0], 0);
      cmp(32'(mcs), 32'h0);
      wr(8'h80 | din[15:8], 5);
      cmp(32'(mcs), 32'h0);
      wr(8'h80, 4);
      cmp(32'(mcs), 32'h80);
      cmp(32'(en), 32'h0);
      wr(8'h00, 1);
      cmp(32'(mcs), 32'h0);
      cmp(32'(en), 32'h1);
      fuse = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      cmp(32'(en), 32'h0);
      fuse = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      cmp(32'(en), 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
